// ---- include/mcu8_exec_pkg.sv ----
// Constants shared by the instruction execute block: opcodes, opcode group
// codes, reset values, vectors, memory layout and timer figures.
// Assumes one 20 MHz clock; every state of the sequencer is one clock except st_iowait, which lasts SYNC_WAIT clocks.
package mcu8_exec_pkg;

	// Single opcodes.
	localparam logic [7:0] OP_NOP      = 8'h00;
	localparam logic [7:0] OP_LATCHED_OUTPUT_BUS = 8'h02;
	localparam logic [7:0] OP_EN_I     = 8'h05;
	localparam logic [7:0] OP_DIS_I    = 8'h15;
	localparam logic [7:0] OP_EN_TCNT  = 8'h25;
	localparam logic [7:0] OP_DIS_TCNT = 8'h35;
	localparam logic [7:0] OP_STRT_CNT = 8'h45;
	localparam logic [7:0] OP_STRT_T   = 8'h55;
	localparam logic [7:0] OP_STOP     = 8'h65;
	localparam logic [7:0] OP_CLK_OUT  = 8'h75;
	localparam logic [7:0] OP_CLR_F0   = 8'h85;
	localparam logic [7:0] OP_CPL_F0   = 8'h95;
	localparam logic [7:0] OP_CLR_F1   = 8'hA5;
	localparam logic [7:0] OP_CPL_F1   = 8'hB5;
	localparam logic [7:0] OP_RB_LOW   = 8'hC5;
	localparam logic [7:0] OP_RB_HIGH  = 8'hD5;
	localparam logic [7:0] OP_MB_LOW   = 8'hE5;
	localparam logic [7:0] OP_MB_HIGH  = 8'hF5;
	localparam logic [7:0] OP_CLR_C    = 8'h97;
	localparam logic [7:0] OP_CPL_C    = 8'hA7;
	localparam logic [7:0] OP_JTF      = 8'h16;
	localparam logic [7:0] OP_JT0      = 8'h36;
	localparam logic [7:0] OP_JT1      = 8'h56;
	localparam logic [7:0] OP_JZ       = 8'hC6;
	localparam logic [7:0] OP_MOV_A_IM = 8'h23;
	localparam logic [7:0] OP_MOV_A_T  = 8'h42;
	localparam logic [7:0] OP_MOV_T_A  = 8'h62;
	localparam logic [7:0] OP_RET      = 8'h83;
	localparam logic [7:0] OP_RETURN_RESTORING_STATUS     = 8'h93;
	localparam logic [7:0] OP_MOVP     = 8'hA3;
	localparam logic [7:0] OP_MOVP3    = 8'hE3;

	// Groups keyed by op[7:3] (register r in op[2:0]).
	localparam logic [4:0] G5_INC_R    = 5'h03;
	localparam logic [4:0] G5_DEC_R    = 5'h19;
	localparam logic [4:0] G5_MOV_R_A  = 5'h15;
	localparam logic [4:0] G5_MOV_A_R  = 5'h1F;
	// Groups keyed by op[7:1] (register r in op[0]).
	localparam logic [6:0] G7_EXTERNAL_DATA_MOVE_RD  = 7'h40;
	localparam logic [6:0] G7_EXTERNAL_DATA_MOVE_WR  = 7'h48;
	localparam logic [6:0] G7_NIBBLE_EXCHANGE     = 7'h18;
	// Groups keyed by op[7:2] (port p in op[1:0]).
	localparam logic [5:0] G6_IN       = 6'h02;
	localparam logic [5:0] G6_LATCHED_OUTPUT_P   = 6'h0E;
	localparam logic [5:0] G6_ANL_P    = 6'h26;
	localparam logic [5:0] G6_ORL_P    = 6'h22;
	localparam logic [5:0] G6_EXPANDER_NIBBLE_MOVE_RD  = 6'h03;
	localparam logic [5:0] G6_EXPANDER_NIBBLE_MOVE_WR  = 6'h0F;
	localparam logic [5:0] G6_EXPANDER_AND     = 6'h27;
	localparam logic [5:0] G6_EXPANDER_OR     = 6'h23;
	// Jump and call keyed by op[4:0], target bits 10..8 in op[7:5].
	localparam logic [4:0] G_JMP       = 5'h04;
	localparam logic [4:0] G_CALL      = 5'h14;

	// Expander command codes.
	localparam logic [1:0] EXP_READ    = 2'h0;
	localparam logic [1:0] EXP_WRITE   = 2'h1;

	// Memory layout.
	localparam logic [6:0] RB_HIGH_BASE = 7'h18;
	localparam logic [6:0] STACK_BASE   = 7'h08;
	localparam logic [2:0] PAGE_THREE   = 3'h3;
	localparam logic [11:0] VEC_EXT     = 12'h003;
	localparam logic [11:0] VEC_TIMER   = 12'h007;
	localparam int          RAM_WORDS   = 128;

	// Reset values.
	localparam logic [11:0] PC_RESET    = 12'h000;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [7:0]  PORT_RESET  = 8'hFF;

	// Timing: cycles a pin sample needs after a strobe, timer prescale.
	localparam logic [1:0] SYNC_WAIT    = 2'h3;
	localparam int         TIMER_DIV    = 32;
	localparam logic [4:0] TIMER_LAST   = 5'(TIMER_DIV - 1);

endpackage

// ---- verification/mcu8_exec_properties.sv ----
// Port checker of the execute block, bound to its top module.
// Assumes one clock domain and the asynchronous low reset.
`timescale 1ns/1ps
module mcu8_exec_properties (
	input wire logic sys_clk,    // Clock
	input wire logic rst_b,      // Reset, low
	input wire logic prog_rd,    // Fetch strobe
	input wire logic xd_rd,      // Data read
	input wire logic xd_wr,      // Data write
	input wire logic bus_oe,     // Bus driven
	input wire logic bus_rd,     // Bus input strobe
	input wire logic exp_strobe, // Expander strobe
	input wire logic t0_out,     // Clock out
	input wire logic t0_oe       // Clock out on
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_clk_run; t0_oe ##1 t0_oe; endsequence
	sequence s_xmove; xd_rd || xd_wr; endsequence
	a_fetch_one_cycle: assert property (prog_rd |=> !prog_rd)
		else $error("fetch strobe too long");
	a_move_exclusive: assert property (xd_wr |-> !xd_rd)
		else $error("read and write strobes together");
	a_move_bus_off: assert property (s_xmove |=> !bus_oe)
		else $error("bus still driven after data move");
	a_bus_hold: assert property ($fell(bus_oe) |->
		xd_rd || xd_wr || $past(xd_rd) || $past(xd_wr))
		else $error("bus released without a data move");
	a_clk_toggle: assert property (s_clk_run |-> t0_out != $past(t0_out))
		else $error("clock output not toggling");
	a_clk_stays: assert property (!$fell(t0_oe))
		else $error("clock output dropped");
	a_exp_pulse: assert property (exp_strobe |=> !exp_strobe)
		else $error("expander strobe too long");
	a_bus_rd_pulse: assert property (bus_rd |=> !bus_rd)
		else $error("bus input strobe too long");
endmodule
bind mcu8_instruction_execute mcu8_exec_properties u_chk (.sys_clk,
	.rst_b, .prog_rd, .xd_rd, .xd_wr, .bus_oe, .bus_rd, .exp_strobe,
	.t0_out, .t0_oe);

// ---- verification/mcu8_instruction_execute_tb_top.sv ----
// Self-checking bench: small programs run, then latches are judged.
// Assumes the checker binds itself and the memory model answers.
`timescale 1ns/1ps
module mcu8_instruction_execute_tb_top;
	import mcu8_exec_pkg::*;
	logic sys_clk = 1'b0, rst_b = 1'b0, t1_in = 1'b0, int_b = 1'b1;
	logic [3:0] exp_data_in = 4'h9;
	logic [11:0] prog_addr;
	logic [7:0] prog_data, xd_addr, xd_wdata, xd_rdata, bus_out, p1_out, p2_out;
	logic prog_rd, xd_wr, xd_rd, bus_oe, bus_rd, exp_strobe, t0_out, t0_oe;
	logic [1:0] exp_port, exp_cmd;
	logic [3:0] exp_data_out;
	logic [5:0] last_exp;
	int fail_count = 0, total_checks = 0;
	always #25 sys_clk = ~sys_clk;
	mcu8_instruction_execute dut (.sys_clk, .rst_b, .prog_addr, .prog_rd,
		.prog_data, .xd_addr, .xd_wdata, .xd_wr, .xd_rd, .xd_rdata,
		.bus_in(8'h5A), .bus_out, .bus_oe, .bus_rd, .p1_in(8'hFF),
		.p2_in(8'hFF), .p1_out, .p2_out, .exp_port, .exp_cmd, .exp_data_out,
		.exp_strobe, .exp_data_in, .t0_in(1'b0), .t0_out, .t0_oe, .t1_in,
		.int_b);
	mcu8_mem_model mem (.sys_clk, .prog_addr, .prog_rd, .prog_data, .xd_addr,
		.xd_wdata, .xd_wr, .xd_rd, .xd_rdata);
	always @(posedge sys_clk)
		if (exp_strobe && exp_cmd === EXP_WRITE)
			last_exp <= {exp_port, exp_data_out};
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic load(input logic [11:0] base, input logic [7:0] img[$]);
		foreach (img[i]) mem.rom[base + 12'(i)] = img[i];
	endtask
	// Programs end in a jump to self; clearing afterwards leaves only no-ops.
	task automatic go(input logic t1);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		t1_in <= t1;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (100) @(posedge sys_clk);
		foreach (mem.rom[i]) mem.rom[i] = 8'h00;
	endtask
	task automatic sc_bus();
		load(0, '{8'h23, 8'h5A, 8'h02, 8'h88, 8'h81, 8'h99, 8'h0F, 8'hA8,
			8'h90, 8'h75, 8'h04, 8'h0A});
		go(1'b0);
		chk(bus_out, 8'hDB);
		chk(p1_out, 8'h0F);
		chk(mem.xram[8'h5A], 8'h5A);
		chk({7'h0, bus_oe}, 8'h00);
		chk({7'h0, t0_oe}, 8'h01);
	endtask
	task automatic sc_branch(input logic t1, input logic [7:0] exp);
		load(0, '{8'h56, 8'h10, 8'hC6, 8'h06, 8'h04, 8'h04, 8'h23, 8'h11,
			8'h02, 8'h04, 8'h09});
		load(12'h010, '{8'hE3, 8'hC6, 8'h15, 8'h02, 8'h04, 8'h14, 8'h04, 8'h15});
		load(12'h300, '{8'h3C});
		go(t1);
		chk(bus_out, exp);
	endtask
	task automatic sc_exp();
		load(0, '{8'h08, 8'h3A, 8'h23, 8'h06, 8'h8D, 8'h0C, 8'h39,
			8'h04, 8'h07});
		go(1'b0);
		chk(p2_out, 8'h5A);
		chk({2'h0, last_exp}, 8'h1F);
		chk(p1_out, 8'h09);
	endtask
	task automatic sc_call();
		load(0, '{8'hF5, 8'h14, 8'h10, 8'h39, 8'hE5, 8'h04, 8'h05});
		load(12'h810, '{8'h23, 8'h15, 8'hA3, 8'h02, 8'h83, 8'h77});
		go(1'b0);
		chk(bus_out, 8'h77);
		chk(p1_out, 8'h77);
	endtask
	task automatic sc_int();
		load(0, '{8'h05, 8'h04, 8'h01, 8'h23, 8'h44, 8'h62, 8'h23, 8'h00,
			8'h42, 8'h3A, 8'h04, 8'h0A});
		int_b <= 1'b0;
		go(1'b0);
		chk(p2_out, 8'h44);
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		// Let the memory model clear its image before the first load.
		@(posedge sys_clk);
		sc_bus();
		sc_branch(1'b1, 8'h3C);
		sc_branch(1'b0, 8'h11);
		sc_exp();
		sc_call();
		sc_int();
		conclude();
	end
	initial begin
		#1000000;
		fail_count++;
		conclude();
	end
endmodule

// ---- verification/mcu8_mem_model.sv ----
// Program memory and external data memory facing the execute block.
// Assumes one-cycle strobes; data stand only in the cycle after.
`timescale 1ns/1ps
module mcu8_mem_model (
	input  wire logic [11:0] prog_addr, // Program address
	input  wire logic        sys_clk,   // Clock
	input  wire logic        prog_rd,   // Program strobe
	output logic      [7:0]  prog_data, // Program byte
	input  wire logic [7:0]  xd_addr,   // Data address
	input  wire logic [7:0]  xd_wdata,  // Write byte
	input  wire logic        xd_wr,     // Write strobe
	input  wire logic        xd_rd,     // Read strobe
	output logic      [7:0]  xd_rdata   // Read byte
);
	logic [7:0] rom [4096];
	logic [7:0] xram [256];
	initial begin
		prog_data = 8'h00;
		xd_rdata = 8'h00;
		foreach (rom[i]) rom[i] = 8'h00;
	end
	// Lines flip outside the answer cycle so a late sample never matches.
	always @(posedge sys_clk) begin
		prog_data <= prog_rd ? rom[prog_addr] : ~prog_data;
		xd_rdata <= xd_rd ? xram[xd_addr] : ~xd_rdata;
		if (xd_wr)
			xram[xd_addr] <= xd_wdata;
	end
endmodule

// ---- verilog/mcu8_instruction_execute.sv ----
// Instruction fetch, decode and execute sequencer of an 8-bit controller.
// Program memory and external data memory sit on this clock and answer a
// read strobe with data in the following cycle; pins pass two flip-flops.
// Operation
// RULE_01 - Bank select ops clear or set bank flip-flop
// RULE_02 - Register bank ops map registers 0-7 or 24-31
// RULE_03 - Page-three lookup: address 011 and accumulator
// RULE_04 - In-page lookup replaces low PC with accumulator
// RULE_05 - Bus output holds until reset or external move
// RULE_06 - Start timer counts from internal prescaler
// RULE_07 - Start counter counts external count input events
// RULE_08 - Stop halts timer, count is held
// RULE_09 - Timer interrupt enable/disable; count load and read
// RULE_10 - External interrupt enable/disable gates vectored call
// RULE_11 - Clock output op drives clock on test pin
// RULE_12 - Nibble exchange swaps low nibbles with data memory
// RULE_13 - Expander AND/OR with accumulator written back
// RULE_14 - Expander nibble moves in and out
// RULE_15 - Immediate AND/OR on ports and bus
// RULE_16 - Bus input strobed; port input and output
// RULE_17 - Test-pin branch taken when pin is one
// RULE_18 - Zero branch taken when accumulator is zero
// RULE_19 - Returns pop PC; restoring form restores status
// RULE_20 - External data moves via register 0/1 address
// RULE_21 - Carry, F0, F1 cleared or complemented alone
// RULE_22 - Selector fields are plain binary numbers
// RULE_23 - Call pushes PC and status, bit 11 from bank
// RULE_24 - All-zero opcode only advances program counter
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module mcu8_instruction_execute
	import mcu8_exec_pkg::*;
(
	input  wire logic        sys_clk,        // 20 MHz clock
	input  wire logic        rst_b,          // Asynchronous reset, low
	output logic [11:0]      prog_addr,      // Program memory address
	output logic             prog_rd,        // Program read strobe
	input  wire logic [7:0]  prog_data,      // Program byte, cycle after
	output logic [7:0]       xd_addr,        // External data address
	output logic [7:0]       xd_wdata,       // External data write byte
	output logic             xd_wr,          // External write strobe
	output logic             xd_rd,          // External read strobe
	input  wire logic [7:0]  xd_rdata,       // External byte, cycle after
	input  wire logic [7:0]  bus_in,         // Bus port pins in
	output logic [7:0]       bus_out,        // Bus port output latch
	output logic             bus_oe,         // Bus port driven
	output logic             bus_rd,         // Strobed bus input pulse
	input  wire logic [7:0]  p1_in,          // Port 1 pins in
	input  wire logic [7:0]  p2_in,          // Port 2 pins in
	output logic [7:0]       p1_out,         // Port 1 latch
	output logic [7:0]       p2_out,         // Port 2 latch
	output logic [1:0]       exp_port,       // Expander port 4..7 less 4
	output logic [1:0]       exp_cmd,        // Expander read or write
	output logic [3:0]       exp_data_out,   // Expander nibble out
	output logic             exp_strobe,     // Expander command pulse
	input  wire logic [3:0]  exp_data_in,    // Expander nibble in
	input  wire logic        t0_in,          // Test pin zero level in
	output logic             t0_out,         // Test pin zero clock out
	output logic             t0_oe,          // Test pin zero driven
	input  wire logic        t1_in,          // Test pin one, count input
	input  wire logic        int_b           // External interrupt, low
);

	typedef enum logic [3:0] {
		st_fetch, st_fwait, st_decode, st_await, st_arg, st_exec,
		st_push2, st_lwait, st_lookup, st_xwait, st_xread, st_iowait,
		st_iodone
	} state_t;

	localparam int SYNC_W = 31;

	state_t            state;
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [7:0]        ram [RAM_WORDS];
	logic              ram_we;
	logic [6:0]        ram_wa;
	logic [7:0]        ram_wd;
	logic [11:0]       pc;
	logic [11:0]       target;
	logic [7:0]        push_hi;
	logic [7:0]        op;
	logic [7:0]        arg;
	logic [7:0]        acc;
	logic              carry;
	logic              aux;
	logic              user_flag_zero;
	logic              user_flag_one;
	logic              register_bank_switch;
	logic              program_bank_flipflop;
	logic [2:0]        stack_pointer;
	logic              ext_int_en;
	logic              tmr_int_en;
	logic              in_service;
	logic              clk_out_en;
	logic [1:0]        wait_cnt;
	logic [7:0]        timer_count;
	logic              timer_run;
	logic              timer_is_counter;
	logic [4:0]        prescale;
	logic              t1_prev;
	logic              timer_overflow_flag;
	logic              timer_count_interrupt;
	logic              cmd_start_t;
	logic              cmd_start_c;
	logic              cmd_stop;
	logic              cmd_load;
	logic              cmd_tf_clear;
	logic              cmd_pend_clear;
	logic              t0_s;
	logic              t1_s;
	logic              int_b_s;
	logic [7:0]        bus_s;
	logic [7:0]        p1_s;
	logic [7:0]        p2_s;
	logic [3:0]        exp_s;
	logic [6:0]        ind_addr;
	logic [6:0]        stk_top;
	logic [7:0]        stk_lo;
	logic [7:0]        stk_hi;
	logic [3:0]        exp_new;
	logic              tick;

	// Working register r lands in the bank chosen by the bank switch.
	function automatic logic [6:0] reg_addr(input logic [2:0] r,
			input logic bs);
		reg_addr = bs ? (RB_HIGH_BASE | {4'h0, r}) : {4'h0, r}; // RULE_02
	endfunction

	function automatic logic [6:0] stack_addr(input logic [2:0] s);
		stack_addr = 7'(STACK_BASE + {3'h0, s, 1'b0});
	endfunction

	function automatic logic two_byte(input logic [7:0] o);
		two_byte = (o == OP_MOV_A_IM) || (o == OP_JT0) || (o == OP_JT1)
			|| (o == OP_JZ) || (o == OP_JTF) || (o[4:0] == G_JMP)
			|| (o[4:0] == G_CALL)
			|| ((o[7:2] == G6_ANL_P) && (o[1:0] != 2'h3))
			|| ((o[7:2] == G6_ORL_P) && (o[1:0] != 2'h3));
	endfunction

	// Every pin passes two flip-flops before any logic reads it.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {t0_in, t1_in, int_b, bus_in, p1_in, p2_in, exp_data_in};
			sync2 <= sync1;
		end
	end

	assign {t0_s, t1_s, int_b_s, bus_s, p1_s, p2_s, exp_s} = sync2;

	// Indirect address uses register 0 or 1 of the current bank.
	assign ind_addr = ram[reg_addr({2'h0, op[0]}, register_bank_switch)][6:0];
	assign stk_top  = stack_addr(3'(stack_pointer - 3'h1));
	assign stk_lo   = ram[stk_top];
	assign stk_hi   = ram[7'(stk_top + 7'h01)];
	assign exp_new  = (op[7:2] == G6_EXPANDER_AND) ? (exp_s & acc[3:0])
		: (exp_s | acc[3:0]);
	assign tick     = timer_is_counter ? (t1_prev && !t1_s)
		: (prescale == TIMER_LAST);

	// The data memory write is registered; the next read of the same
	// location is at least two fetch cycles away, so no bypass is needed.
	always_ff @(posedge sys_clk) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

	// Timer and event counter; set of a flag wins over its clear.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_count           <= BYTE_RESET;
			timer_run             <= 1'b0;
			timer_is_counter      <= 1'b0;
			prescale              <= '0;
			t1_prev               <= 1'b0;
			timer_overflow_flag   <= 1'b0;
			timer_count_interrupt <= 1'b0;
		end else begin
			t1_prev  <= t1_s;
			prescale <= 5'(prescale + 5'h01);
			if (cmd_start_t) begin
				timer_run        <= 1'b1; // RULE_06
				timer_is_counter <= 1'b0; // RULE_06
				prescale         <= '0;
			end
			if (cmd_start_c) begin
				timer_run        <= 1'b1; // RULE_07
				timer_is_counter <= 1'b1; // RULE_07
			end
			if (cmd_stop) begin
				timer_run <= 1'b0; // RULE_08
			end
			if (cmd_tf_clear) begin
				timer_overflow_flag <= 1'b0;
			end
			if (cmd_pend_clear) begin
				timer_count_interrupt <= 1'b0;
			end
			if (cmd_load) begin
				timer_count <= acc; // RULE_09
			end else if (timer_run && tick) begin
				timer_count <= 8'(timer_count + 8'h01);
				if (timer_count == 8'hFF) begin
					timer_overflow_flag   <= 1'b1;
					timer_count_interrupt <= 1'b1;
				end
			end
		end
	end

	// Test pin zero as a clock output: half the system clock rate.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			t0_out <= 1'b0;
			t0_oe  <= 1'b0;
		end else begin
			t0_oe  <= clk_out_en; // RULE_11
			t0_out <= clk_out_en ? !t0_out : 1'b0; // RULE_11
		end
	end

	// Fetch, decode and execute sequencer.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state                 <= st_fetch;
			pc                    <= PC_RESET;
			target                <= PC_RESET;
			push_hi               <= BYTE_RESET;
			op                    <= OP_NOP;
			arg                   <= BYTE_RESET;
			acc                   <= BYTE_RESET;
			carry                 <= 1'b0;
			aux                   <= 1'b0;
			user_flag_zero        <= 1'b0;
			user_flag_one         <= 1'b0;
			register_bank_switch  <= 1'b0;
			program_bank_flipflop <= 1'b0;
			stack_pointer         <= '0;
			ext_int_en            <= 1'b0;
			tmr_int_en            <= 1'b0;
			in_service            <= 1'b0;
			clk_out_en            <= 1'b0;
			wait_cnt              <= '0;
			ram_we                <= 1'b0;
			ram_wa                <= '0;
			ram_wd                <= BYTE_RESET;
			prog_addr             <= PC_RESET;
			prog_rd               <= 1'b0;
			xd_addr               <= BYTE_RESET;
			xd_wdata              <= BYTE_RESET;
			xd_wr                 <= 1'b0;
			xd_rd                 <= 1'b0;
			bus_out               <= BYTE_RESET;
			bus_oe                <= 1'b0; // RULE_05
			bus_rd                <= 1'b0;
			p1_out                <= PORT_RESET;
			p2_out                <= PORT_RESET;
			exp_port              <= '0;
			exp_cmd               <= EXP_READ;
			exp_data_out          <= '0;
			exp_strobe            <= 1'b0;
			cmd_start_t           <= 1'b0;
			cmd_start_c           <= 1'b0;
			cmd_stop              <= 1'b0;
			cmd_load              <= 1'b0;
			cmd_tf_clear          <= 1'b0;
			cmd_pend_clear        <= 1'b0;
		end else begin
			prog_rd        <= 1'b0;
			xd_rd          <= 1'b0;
			xd_wr          <= 1'b0;
			bus_rd         <= 1'b0;
			exp_strobe     <= 1'b0;
			ram_we         <= 1'b0;
			cmd_start_t    <= 1'b0;
			cmd_start_c    <= 1'b0;
			cmd_stop       <= 1'b0;
			cmd_load       <= 1'b0;
			cmd_tf_clear   <= 1'b0;
			cmd_pend_clear <= 1'b0;
			unique case (state)
			st_fetch: begin
				// Vectored calls push the unadvanced program counter.
				if (ext_int_en && !int_b_s && !in_service) begin // RULE_10
					in_service <= 1'b1;
					target     <= VEC_EXT;
					ram_we     <= 1'b1;
					ram_wa     <= stack_addr(stack_pointer);
					ram_wd     <= pc[7:0];
					push_hi    <= {carry, aux, user_flag_zero,
						register_bank_switch, pc[11:8]};
					state      <= st_push2;
				end else if (tmr_int_en && timer_count_interrupt
						&& !in_service) begin // RULE_09
					in_service     <= 1'b1;
					cmd_pend_clear <= 1'b1;
					target         <= VEC_TIMER;
					ram_we         <= 1'b1;
					ram_wa         <= stack_addr(stack_pointer);
					ram_wd         <= pc[7:0];
					push_hi        <= {carry, aux, user_flag_zero,
						register_bank_switch, pc[11:8]};
					state          <= st_push2;
				end else begin
					prog_addr <= pc;
					prog_rd   <= 1'b1;
					state     <= st_fwait;
				end
			end
			st_fwait: begin
				state <= st_decode;
			end
			st_decode: begin
				op <= prog_data;
				pc <= 12'(pc + 12'h001); // RULE_24
				if (two_byte(prog_data)) begin
					prog_addr <= 12'(pc + 12'h001);
					prog_rd   <= 1'b1;
					state     <= st_await;
				end else begin
					state <= st_exec;
				end
			end
			st_await: begin
				state <= st_arg;
			end
			st_arg: begin
				arg   <= prog_data;
				pc    <= 12'(pc + 12'h001); // RULE_17
				state <= st_exec;
			end
			st_exec: begin
				state <= st_fetch;
				unique case (op)
				OP_EN_I:     ext_int_en <= 1'b1; // RULE_10
				OP_DIS_I:    ext_int_en <= 1'b0; // RULE_10
				OP_EN_TCNT:  tmr_int_en <= 1'b1; // RULE_09
				OP_DIS_TCNT: begin
					tmr_int_en     <= 1'b0; // RULE_09
					cmd_pend_clear <= 1'b1;
				end
				OP_STRT_T:   cmd_start_t <= 1'b1; // RULE_06
				OP_STRT_CNT: cmd_start_c <= 1'b1; // RULE_07
				OP_STOP:     cmd_stop <= 1'b1; // RULE_08
				OP_MOV_A_T:  acc <= timer_count; // RULE_09
				OP_MOV_T_A:  cmd_load <= 1'b1; // RULE_09
				OP_CLK_OUT:  clk_out_en <= 1'b1; // RULE_11
				OP_MB_LOW:   program_bank_flipflop <= 1'b0; // RULE_01
				OP_MB_HIGH:  program_bank_flipflop <= 1'b1; // RULE_01
				OP_RB_LOW:   register_bank_switch <= 1'b0; // RULE_02
				OP_RB_HIGH:  register_bank_switch <= 1'b1; // RULE_02
				OP_CLR_C:    carry <= 1'b0; // RULE_21
				OP_CPL_C:    carry <= !carry; // RULE_21
				OP_CLR_F0:   user_flag_zero <= 1'b0; // RULE_21
				OP_CPL_F0:   user_flag_zero <= !user_flag_zero; // RULE_21
				OP_CLR_F1:   user_flag_one <= 1'b0; // RULE_21
				OP_CPL_F1:   user_flag_one <= !user_flag_one; // RULE_21
				OP_MOV_A_IM: acc <= arg;
				OP_JT0: begin
					if (t0_s) pc[7:0] <= arg; // RULE_17
				end
				OP_JT1: begin
					if (t1_s) pc[7:0] <= arg; // RULE_17
				end
				OP_JZ: begin
					if (acc == 8'h00) pc[7:0] <= arg; // RULE_18
				end
				OP_JTF: begin
					cmd_tf_clear <= 1'b1;
					if (timer_overflow_flag) pc[7:0] <= arg;
				end
				OP_LATCHED_OUTPUT_BUS: begin
					bus_out <= acc; // RULE_05
					bus_oe  <= 1'b1; // RULE_05
				end
				OP_RET, OP_RETURN_RESTORING_STATUS: begin
					stack_pointer <= 3'(stack_pointer - 3'h1); // RULE_19
					pc <= {stk_hi[3:0], stk_lo}; // RULE_19
					if (op == OP_RETURN_RESTORING_STATUS) begin
						{carry, aux, user_flag_zero, register_bank_switch}
							<= stk_hi[7:4]; // RULE_19
						in_service <= 1'b0;
					end
				end
				OP_MOVP: begin
					prog_addr <= {pc[11:8], acc}; // RULE_04
					prog_rd   <= 1'b1;
					state     <= st_lwait;
				end
				OP_MOVP3: begin
					prog_addr <= {pc[11], PAGE_THREE, acc}; // RULE_03
					prog_rd   <= 1'b1;
					state     <= st_lwait;
				end
				default: begin
					// Grouped opcodes carry a binary selector field.
					if (op[4:0] == G_JMP) begin
						pc <= {program_bank_flipflop, op[7:5], arg};
					end else if (op[4:0] == G_CALL) begin
						target  <= {program_bank_flipflop, op[7:5], arg}; // RULE_23
						ram_we  <= 1'b1;
						ram_wa  <= stack_addr(stack_pointer); // RULE_23
						ram_wd  <= pc[7:0]; // RULE_23
						push_hi <= {carry, aux, user_flag_zero,
							register_bank_switch, pc[11:8]}; // RULE_23
						state   <= st_push2;
					end else if (op[7:3] == G5_INC_R) begin
						ram_we <= 1'b1;
						ram_wa <= reg_addr(op[2:0], register_bank_switch); // RULE_22
						ram_wd <= 8'(ram[reg_addr(op[2:0],
							register_bank_switch)] + 8'h01);
					end else if (op[7:3] == G5_DEC_R) begin
						ram_we <= 1'b1;
						ram_wa <= reg_addr(op[2:0], register_bank_switch); // RULE_22
						ram_wd <= 8'(ram[reg_addr(op[2:0],
							register_bank_switch)] - 8'h01);
					end else if (op[7:3] == G5_MOV_R_A) begin
						ram_we <= 1'b1;
						ram_wa <= reg_addr(op[2:0], register_bank_switch); // RULE_22
						ram_wd <= acc;
					end else if (op[7:3] == G5_MOV_A_R) begin
						acc <= ram[reg_addr(op[2:0], register_bank_switch)];
					end else if (op[7:1] == G7_NIBBLE_EXCHANGE) begin
						ram_we <= 1'b1;
						ram_wa <= ind_addr;
						ram_wd <= {ram[ind_addr][7:4], acc[3:0]}; // RULE_12
						acc    <= {acc[7:4], ram[ind_addr][3:0]}; // RULE_12
					end else if (op[7:1] == G7_EXTERNAL_DATA_MOVE_RD) begin
						xd_addr <= {1'b0, ind_addr}; // RULE_20
						xd_rd   <= 1'b1; // RULE_20
						bus_oe  <= 1'b0; // RULE_05
						state   <= st_xwait;
					end else if (op[7:1] == G7_EXTERNAL_DATA_MOVE_WR) begin
						xd_addr  <= {1'b0, ind_addr}; // RULE_20
						xd_wdata <= acc; // RULE_20
						xd_wr    <= 1'b1; // RULE_20
						bus_oe   <= 1'b0; // RULE_05
					end else if (op[7:2] == G6_IN) begin
						if (op[1:0] == 2'h0) begin
							bus_rd   <= 1'b1; // RULE_16
							wait_cnt <= SYNC_WAIT;
							state    <= st_iowait;
						end else begin
							acc <= op[1] ? p2_s : p1_s; // RULE_16
						end
					end else if (op[7:2] == G6_LATCHED_OUTPUT_P) begin
						if (op[1:0] == 2'h1) p1_out <= acc; // RULE_16
						if (op[1:0] == 2'h2) p2_out <= acc; // RULE_16
					end else if (op[7:2] == G6_ANL_P) begin
						if (op[1:0] == 2'h0) bus_out <= bus_out & arg; // RULE_15
						if (op[1:0] == 2'h1) p1_out <= p1_out & arg; // RULE_15
						if (op[1:0] == 2'h2) p2_out <= p2_out & arg; // RULE_15
					end else if (op[7:2] == G6_ORL_P) begin
						if (op[1:0] == 2'h0) bus_out <= bus_out | arg; // RULE_15
						if (op[1:0] == 2'h1) p1_out <= p1_out | arg; // RULE_15
						if (op[1:0] == 2'h2) p2_out <= p2_out | arg; // RULE_15
					end else if (op[7:2] == G6_EXPANDER_NIBBLE_MOVE_WR) begin
						exp_port     <= op[1:0]; // RULE_14
						exp_cmd      <= EXP_WRITE;
						exp_data_out <= acc[3:0]; // RULE_14
						exp_strobe   <= 1'b1;
					end else if ((op[7:2] == G6_EXPANDER_NIBBLE_MOVE_RD)
							|| (op[7:2] == G6_EXPANDER_AND)
							|| (op[7:2] == G6_EXPANDER_OR)) begin
						exp_port   <= op[1:0]; // RULE_22
						exp_cmd    <= EXP_READ;
						exp_strobe <= 1'b1;
						wait_cnt   <= SYNC_WAIT;
						state      <= st_iowait;
					end
				end
				endcase
			end
			st_push2: begin
				ram_we        <= 1'b1;
				ram_wa        <= 7'(ram_wa + 7'h01);
				ram_wd        <= push_hi; // RULE_23
				stack_pointer <= 3'(stack_pointer + 3'h1); // RULE_23
				pc            <= target; // RULE_23
				state         <= st_fetch;
			end
			st_lwait: begin
				state <= st_lookup;
			end
			st_lookup: begin
				acc   <= prog_data; // RULE_03
				state <= st_fetch;
			end
			st_xwait: begin
				state <= st_xread;
			end
			st_xread: begin
				acc   <= xd_rdata; // RULE_20
				state <= st_fetch;
			end
			st_iowait: begin
				// The sampled pins trail the strobe by the synchroniser.
				wait_cnt <= 2'(wait_cnt - 2'h1);
				if (wait_cnt == 2'h1) state <= st_iodone;
			end
			st_iodone: begin
				state <= st_fetch;
				if (op[7:2] == G6_IN) begin
					acc <= bus_s; // RULE_16
				end else if (op[7:2] == G6_EXPANDER_NIBBLE_MOVE_RD) begin
					acc[3:0] <= exp_s; // RULE_14
				end else begin
					exp_cmd      <= EXP_WRITE;
					exp_data_out <= exp_new; // RULE_13
					exp_strobe   <= 1'b1; // RULE_13
				end
			end
			endcase
		end
	end

endmodule
